// *** src/dmcc_pkg.sv ***
// Shared constants for the distance median and cover compensation block
`default_nettype none
package dmcc_pkg;
    // Register offsets
    localparam logic [7:0] OFF_RUN_CONTROL    = 8'h03;
    localparam logic [7:0] OFF_MEDIAN_WINDOW  = 8'h3f;
    localparam logic [7:0] OFF_CAPTURE_SETUP  = 8'h4c;
    localparam logic [7:0] OFF_EXPOSURE_HIGH  = 8'h64;
    localparam logic [7:0] OFF_EXPOSURE_LOW   = 8'h65;
    localparam logic [7:0] OFF_GAIN_CODE      = 8'h67;
    localparam logic [7:0] OFF_COEFF_LOW      = 8'h8d;
    localparam logic [7:0] OFF_COEFF_HIGH     = 8'h8e;
    localparam logic [7:0] OFF_COMP_ENABLE    = 8'h8f;
    localparam logic [7:0] OFF_PLANE_SELECT   = 8'h90;
    localparam logic [7:0] OFF_MEAS_TRIGGER   = 8'hec;
    localparam logic [7:0] OFF_BANK_SELECT    = 8'hef;
    // Reset values
    localparam logic [7:0] RST_RUN_CONTROL    = 8'h01;
    localparam logic [7:0] RST_MEDIAN_WINDOW  = 8'h01;
    localparam logic [7:0] RST_ZERO           = 8'h00;
    // Field positions of the coefficient bytes
    localparam int         COEFF_LOW_LSB      = 2;
    localparam int         COEFF_LOW_W        = 6;
    localparam int         COEFF_HIGH_W       = 5;
    localparam int         COEFF_W            = 11;
    // Command and mode codes
    localparam logic [7:0] COMP_ON_CODE       = 8'h02;
    localparam logic [7:0] TRIGGER_CODE       = 8'hff;
    localparam logic [7:0] PRIMARY_BANK_CODE  = 8'h00;
    localparam logic [7:0] PLANE_LOW_CODE     = 8'h10;
    localparam logic [7:0] PLANE_MID_CODE     = 8'h11;
    localparam logic [7:0] PLANE_HIGH_CODE    = 8'h12;
    localparam logic [3:0] WIN_LEN_1          = 4'h1;
    localparam logic [3:0] WIN_LEN_5          = 4'h5;
    localparam logic [3:0] WIN_LEN_7          = 4'h7;
    localparam logic [3:0] WIN_LEN_9          = 4'h9;
    // Profile geometry, defaults and bus bit counts
    localparam int         PROFILE_LEN        = 220;
    localparam logic [7:0] PROFILE_LAST_OFF   = 8'hdb;
    localparam int         PROFILE_W          = 24;
    localparam logic [7:0] ACCUM_DEFAULT      = 8'h0a;
    localparam logic [6:0] I2C_ADDR_DEFAULT   = 7'h40;
    localparam logic [3:0] BIT_ACK            = 4'h8;
    localparam logic [3:0] BIT_LAST_DATA      = 4'h7;
    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_OFFS,
        I2C_WDATA,
        I2C_RDATA
    } dmcc_i2c_state_t;
endpackage
`default_nettype wire

// *** src/dmcc_median.sv ***
// Sliding median over the last N distance measurements
`default_nettype none
module dmcc_median #(
    parameter int MAXN = 9,
    parameter int W    = 12
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_dist,
    input  wire logic [3:0]   win_len,
    output logic              out_valid,
    output logic [W-1:0]      out_dist,
    output logic              out_settled
);
    import dmcc_pkg::*;

    logic [W-1:0] win_r [MAXN];
    logic [3:0]   fill_r;
    logic [3:0]   len_r;
    logic         pend_r;
    logic [W-1:0] med;
    int           rank;
    int           half;
    int           n;

    // Window shift, newest in slot 0
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < MAXN; i++)
                win_r[i] <= '0;
        end
        else if (in_valid)
        begin
            win_r[0] <= in_dist;
            for (int i = 1; i < MAXN; i++)
                win_r[i] <= win_r[i-1];
        end
    end

    // Fill count restarts when the window length changes
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fill_r <= '0;
            len_r  <= WIN_LEN_1;
        end
        else if (win_len != len_r)
        begin
            len_r  <= win_len;
            fill_r <= '0;
        end
        else if (in_valid && fill_r < len_r)
            fill_r <= fill_r + 4'h1;
    end

    // Rank selection over the first N slots
    always_comb
    begin
        n    = int'(len_r);
        half = (n - 1) / 2;
        med  = win_r[0];
        for (int i = 0; i < MAXN; i++)
        begin
            rank = 0;
            for (int j = 0; j < MAXN; j++)
                if (j != i && j < n &&
                    ((win_r[j] < win_r[i]) || (win_r[j] == win_r[i] && j < i)))
                    rank = rank + 1;
            if (i < n && rank == half)
                med = win_r[i];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            pend_r <= 1'b0;
        else
            pend_r <= in_valid;
    end

    // Output two cycles after each measurement
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            out_valid   <= 1'b0;
            out_dist    <= '0;
            out_settled <= 1'b0;
        end
        else
        begin
            out_valid <= pend_r;
            if (pend_r)
            begin
                out_settled <= (fill_r >= len_r);
                out_dist    <= (fill_r >= len_r) ? med : win_r[0];
            end
        end
    end
endmodule
`default_nettype wire

// *** src/dmcc_top.sv ***
// Distance post-processing with register port over a two-wire bus
//
// Overview of operation
// - Median window length selectable as five, seven or nine measurements.
// - With window N, output median of N values once N measurements done.
// - Distance output from first measurement; pre-fill outputs flagged unsettled.
// - After filling, window slides one step and median refreshes each measurement.
// - Window selection held in writable primary-bank register median_window_select.
// - Default window one, no filtering; default accumulation count ten.
// - When compensation active, subtract slope term from the profile.
// - Coefficient low six bits come from bits 7..2 of register cover_coeff_low.
// - Coefficient upper five bits come from bits 4..0 of register cover_coeff_high.
// - Writing 0x02 to cover_comp_enable enables compensated output.
// - Exposure high exposure_high_byte, low exposure_low_byte, gain gain_code readable by host.
// - Register profile_plane_select value 0x10/0x11/0x12 selects low/middle/high plane.
// - Burst read 0x00..0xDB returns selected plane's 220 samples in order.
`default_nettype none
module dmcc_top #(
    parameter logic [6:0] DEV_ADDR = dmcc_pkg::I2C_ADDR_DEFAULT,
    parameter int         DIST_W   = 12
) (
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    input  wire logic                     scl,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe_n,
    input  wire logic                     meas_valid,
    input  wire logic [DIST_W-1:0]        meas_dist,
    input  wire logic [15:0]              exposure_value,
    input  wire logic [7:0]               gain_factor,
    input  wire logic                     prof_we,
    input  wire logic [7:0]               prof_idx,
    input  wire logic [dmcc_pkg::PROFILE_W-1:0] prof_data,
    output logic                          dist_valid,
    output logic [DIST_W-1:0]             dist_out,
    output logic                          dist_settled,
    output logic                          comp_valid,
    output logic [7:0]                    comp_idx,
    output logic [dmcc_pkg::PROFILE_W-1:0] comp_data,
    output logic                          comp_active,
    output logic                          meas_start,
    output logic [7:0]                    run_control,
    output logic [7:0]                    capture_setup,
    output logic [7:0]                    accum_count
);
    import dmcc_pkg::*;

    logic [7:0]            run_control_r;
    logic [7:0]            median_window_r;
    logic [7:0]            capture_setup_r;
    logic [7:0]            coeff_low_r;
    logic [7:0]            coeff_high_r;
    logic [7:0]            comp_enable_r;
    logic [7:0]            plane_select_r;
    logic [7:0]            trigger_r;
    logic [7:0]            bank_select_r;
    logic [PROFILE_W-1:0]  profile_mem [PROFILE_LEN];
    logic                  scl_q;
    logic                  sda_q;
    dmcc_i2c_state_t       state_r;
    logic [3:0]            bit_r;
    logic [7:0]            shift_r;
    logic [7:0]            tx_r;
    logic [7:0]            off_r;
    logic                  ack_r;
    logic                  wr_r;
    logic [7:0]            wr_off_r;
    logic [7:0]            wr_data_r;
    logic [7:0]            rd_byte;
    logic [3:0]            win_len;
    logic [COEFF_W-1:0]    coeff;
    logic [18:0]           slope_term;
    logic [PROFILE_W-1:0]  slope_ext;
    logic                  start_cond;
    logic                  stop_cond;
    logic                  scl_rise;
    logic                  scl_fall;

    assign start_cond = scl && scl_q && sda_q && !sda_in;
    assign stop_cond  = scl && scl_q && !sda_q && sda_in;
    assign scl_rise   = scl && !scl_q;
    assign scl_fall   = !scl && scl_q;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    // Two-wire register port protocol
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r   <= I2C_IDLE;
            bit_r     <= '0;
            shift_r   <= '0;
            tx_r      <= 8'hff;
            off_r     <= '0;
            ack_r     <= 1'b0;
            wr_r      <= 1'b0;
            wr_off_r  <= '0;
            wr_data_r <= '0;
        end
        else
        begin
            wr_r <= 1'b0;
            if (start_cond)
            begin
                state_r <= I2C_ADDR;
                // Fall after START wraps the count to zero before bit 0
                bit_r   <= '1;
                ack_r   <= 1'b0;
                tx_r    <= 8'hff;
            end
            else if (stop_cond)
            begin
                state_r <= I2C_IDLE;
                ack_r   <= 1'b0;
            end
            else if (state_r != I2C_IDLE && scl_rise)
            begin
                if (bit_r < BIT_ACK)
                    shift_r <= {shift_r[6:0], sda_in};
                else if (state_r == I2C_RDATA && sda_in)
                    state_r <= I2C_IDLE;
            end
            else if (state_r != I2C_IDLE && scl_fall)
            begin
                if (bit_r == BIT_LAST_DATA)
                begin
                    bit_r <= BIT_ACK;
                    tx_r  <= 8'hff;
                    case (state_r)
                        I2C_ADDR:
                        begin
                            if (shift_r[7:1] == DEV_ADDR)
                            begin
                                ack_r   <= 1'b1;
                                state_r <= shift_r[0] ? I2C_RDATA : I2C_OFFS;
                            end
                            else
                                state_r <= I2C_IDLE;
                        end
                        I2C_OFFS:
                        begin
                            ack_r   <= 1'b1;
                            off_r   <= shift_r;
                            state_r <= I2C_WDATA;
                        end
                        I2C_WDATA:
                        begin
                            ack_r     <= 1'b1;
                            wr_r      <= 1'b1;
                            wr_off_r  <= off_r;
                            wr_data_r <= shift_r;
                            off_r     <= off_r + 8'h01;
                        end
                        default:
                            ack_r <= 1'b0;
                    endcase
                end
                else if (bit_r == BIT_ACK)
                begin
                    bit_r <= '0;
                    ack_r <= 1'b0;
                    if (state_r == I2C_RDATA)
                    begin
                        tx_r  <= rd_byte;
                        off_r <= off_r + 8'h01;
                    end
                end
                else
                begin
                    bit_r <= bit_r + 4'h1;
                    tx_r  <= {tx_r[6:0], 1'b1};
                end
            end
        end
    end

    // Open-drain data pin, enable low while pulling low
    assign sda_out  = 1'b0;
    assign sda_oe_n = !((bit_r == BIT_ACK && ack_r) ||
                        (state_r == I2C_RDATA && bit_r < BIT_ACK && !tx_r[7]));

    // Host-written registers
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            run_control_r   <= RST_RUN_CONTROL;
            median_window_r <= RST_MEDIAN_WINDOW;
            capture_setup_r <= RST_ZERO;
            coeff_low_r     <= RST_ZERO;
            coeff_high_r    <= RST_ZERO;
            comp_enable_r   <= RST_ZERO;
            plane_select_r  <= RST_ZERO;
            trigger_r       <= RST_ZERO;
            bank_select_r   <= RST_ZERO;
        end
        else if (wr_r)
        begin
            case (wr_off_r)
                OFF_RUN_CONTROL:   run_control_r   <= wr_data_r;
                OFF_MEDIAN_WINDOW: median_window_r <= wr_data_r;
                OFF_CAPTURE_SETUP: capture_setup_r <= wr_data_r;
                OFF_COEFF_LOW:     coeff_low_r     <= wr_data_r;
                OFF_COEFF_HIGH:    coeff_high_r    <= wr_data_r;
                OFF_COMP_ENABLE:   comp_enable_r   <= wr_data_r;
                OFF_PLANE_SELECT:  plane_select_r  <= wr_data_r;
                OFF_MEAS_TRIGGER:  trigger_r       <= wr_data_r;
                OFF_BANK_SELECT:   bank_select_r   <= wr_data_r;
                default:           trigger_r       <= trigger_r;
            endcase
        end
    end

    // Measurement start pulse on trigger write in the primary bank
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            meas_start <= 1'b0;
        else
            meas_start <= wr_r && wr_off_r == OFF_MEAS_TRIGGER &&
                          wr_data_r == TRIGGER_CODE &&
                          bank_select_r == PRIMARY_BANK_CODE;
    end

    // Read data: profile plane at offsets 0x00..0xDB while selected, else register file
    always_comb
    begin
        rd_byte = 8'h00;
        if (off_r <= PROFILE_LAST_OFF && plane_select_r == PLANE_LOW_CODE)
            rd_byte = profile_mem[off_r][7:0];
        else if (off_r <= PROFILE_LAST_OFF && plane_select_r == PLANE_MID_CODE)
            rd_byte = profile_mem[off_r][15:8];
        else if (off_r <= PROFILE_LAST_OFF && plane_select_r == PLANE_HIGH_CODE)
            rd_byte = profile_mem[off_r][23:16];
        else
        begin
            case (off_r)
                OFF_RUN_CONTROL:   rd_byte = run_control_r;
                OFF_MEDIAN_WINDOW: rd_byte = median_window_r;
                OFF_CAPTURE_SETUP: rd_byte = capture_setup_r;
                OFF_EXPOSURE_HIGH: rd_byte = exposure_value[15:8];
                OFF_EXPOSURE_LOW:  rd_byte = exposure_value[7:0];
                OFF_GAIN_CODE:     rd_byte = gain_factor;
                OFF_COEFF_LOW:     rd_byte = coeff_low_r;
                OFF_COEFF_HIGH:    rd_byte = coeff_high_r;
                OFF_COMP_ENABLE:   rd_byte = comp_enable_r;
                OFF_PLANE_SELECT:  rd_byte = plane_select_r;
                OFF_MEAS_TRIGGER:  rd_byte = trigger_r;
                OFF_BANK_SELECT:   rd_byte = bank_select_r;
                default:           rd_byte = 8'h00;
            endcase
        end
    end

    // Raw profile store, one 24-bit word per pixel
    always_ff @(posedge ref_clk)
    begin
        if (prof_we && int'(prof_idx) < PROFILE_LEN)
            profile_mem[prof_idx] <= prof_data;
    end

    // Cover compensation
    assign coeff = {coeff_high_r[COEFF_HIGH_W-1:0],
                    coeff_low_r[COEFF_LOW_LSB +: COEFF_LOW_W]};
    assign comp_active = (comp_enable_r == COMP_ON_CODE);
    assign slope_term  = 19'(coeff) * 19'(prof_idx);
    assign slope_ext   = {5'h00, slope_term};

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            comp_valid <= 1'b0;
            comp_idx   <= '0;
            comp_data  <= '0;
        end
        else
        begin
            comp_valid <= prof_we;
            if (prof_we)
            begin
                comp_idx <= prof_idx;
                if (!comp_active)
                    comp_data <= prof_data;
                else if (prof_data > slope_ext)
                    comp_data <= prof_data - slope_ext;
                else
                    comp_data <= '0;
            end
        end
    end

    // Window length decode, unsupported codes mean no filtering
    always_comb
    begin
        case (median_window_r[3:0])
            WIN_LEN_5: win_len = WIN_LEN_5;
            WIN_LEN_7: win_len = WIN_LEN_7;
            WIN_LEN_9: win_len = WIN_LEN_9;
            default:   win_len = WIN_LEN_1;
        endcase
    end

    dmcc_median #(
        .MAXN (9),
        .W    (DIST_W)
    ) u_median (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .in_valid    (meas_valid),
        .in_dist     (meas_dist),
        .win_len     (win_len),
        .out_valid   (dist_valid),
        .out_dist    (dist_out),
        .out_settled (dist_settled)
    );

    assign run_control   = run_control_r;
    assign capture_setup = capture_setup_r;
    assign accum_count   = ACCUM_DEFAULT;
endmodule
`default_nettype wire

// *** bench/dmcc_top_sva.sv ***
// Checker for the measurement and profile outputs of dmcc_top
`default_nettype none
module dmcc_top_sva #(
    parameter int DIST_W = 12
) (
    input wire logic              ref_clk,
    input wire logic              resetn,
    input wire logic              meas_valid,
    input wire logic              dist_valid,
    input wire logic [DIST_W-1:0] dist_out,
    input wire logic              dist_settled,
    input wire logic              prof_we,
    input wire logic [7:0]        prof_idx,
    input wire logic [23:0]       prof_data,
    input wire logic              comp_valid,
    input wire logic [7:0]        comp_idx,
    input wire logic [23:0]       comp_data,
    input wire logic              comp_active,
    input wire logic [7:0]        accum_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    property p_dist_lat;
        meas_valid |-> ##2 dist_valid;
    endproperty
    a_dist_lat: assert property (p_dist_lat) else $error("distance late");
    property p_dist_cause;
        dist_valid |-> $past(meas_valid, 2);
    endproperty
    a_dist_cause: assert property (p_dist_cause) else $error("distance uncaused");
    property p_settle;
        $rose(dist_settled) |-> dist_valid;
    endproperty
    a_settle: assert property (p_settle) else $error("settled off output");
    property p_comp_cause;
        comp_valid |-> $past(prof_we) && comp_idx == $past(prof_idx);
    endproperty
    a_comp_cause: assert property (p_comp_cause) else $error("pixel uncaused");
    property p_comp_pass;
        prof_we && !comp_active |=> comp_data == $past(prof_data);
    endproperty
    a_comp_pass: assert property (p_comp_pass) else $error("pixel altered");
    property p_comp_sub;
        prof_we && comp_active |=> comp_data <= $past(prof_data);
    endproperty
    a_comp_sub: assert property (p_comp_sub) else $error("pixel grew");
    property p_comp_zero;
        prof_we && prof_idx == 8'h00 |=> comp_data == $past(prof_data);
    endproperty
    a_comp_zero: assert property (p_comp_zero) else $error("pixel 0 altered");
    property p_accum;
        accum_count == 8'h0a;
    endproperty
    a_accum: assert property (p_accum) else $error("accumulation count");
    c_settled: cover property (dist_valid && dist_settled);
    c_unsettle: cover property ($fell(dist_settled));
    c_comp: cover property (prof_we && comp_active);
endmodule
bind dmcc_top dmcc_top_sva #(.DIST_W(DIST_W)) dmcc_top_sva_i (.ref_clk, .resetn,
    .meas_valid, .dist_valid, .dist_out, .dist_settled, .prof_we, .prof_idx, .prof_data,
    .comp_valid, .comp_idx, .comp_data, .comp_active, .accum_count);
`default_nettype wire

// *** bench/dmcc_host.sv ***
// Two-wire bus controller model standing in for the host
`default_nettype none
module dmcc_host #(
    parameter logic [6:0] ADDR = 7'h40
) (
    input  wire logic ref_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      rel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rq[$];
    int         nacks = 0;
    initial
    begin
        scl = 1'b1;
        rel = 1'b1;
    end
    task automatic clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        @(posedge ref_clk) scl <= 1'b0;
        @(posedge ref_clk) rel <= b;
        @(posedge ref_clk) scl <= 1'b1;
        clk(2);
        r = sda;
    endtask
    task automatic sb(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        if (r)
            nacks++;
    endtask
    task automatic edge_c(input logic first);
        @(posedge ref_clk) scl <= 1'b0;
        @(posedge ref_clk) rel <= first;
        @(posedge ref_clk) scl <= 1'b1;
        clk(2);
        rel <= !first;
        clk(2);
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        edge_c(1'b1);
        sb({ADDR, 1'b0});
        sb(off);
        sb(d);
        edge_c(1'b0);
    endtask
    task automatic rd(input logic [7:0] off, input int n);
        logic [7:0] d;
        logic       r;
        rq.delete();
        edge_c(1'b1);
        sb({ADDR, 1'b0});
        sb(off);
        edge_c(1'b1);
        sb({ADDR, 1'b1});
        for (int k = 0; k < n; k++)
        begin
            for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
            bit_io(k == n - 1, r);
            rq.push_back(d);
        end
        edge_c(1'b0);
    endtask
endmodule
`default_nettype wire

// *** bench/test_distance_median_cover_comp.sv ***
// Self-checking bench for the distance median and cover compensation block
`default_nettype none
module test_distance_median_cover_comp;
    timeunit 1ns;
    timeprecision 1ps;
    import dmcc_pkg::*;
    localparam int         WAIT_CYC = 40;
    localparam logic [7:0] WINS[5] = '{8'h05, 8'h07, 8'h09, 8'h01, 8'h03};
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        meas_valid = 1'b0;
    logic [11:0] meas_dist = '0;
    logic [15:0] exposure_value = '0;
    logic [7:0]  gain_factor = '0;
    logic        prof_we = 1'b0;
    logic [7:0]  prof_idx = '0;
    logic [23:0] prof_data = '0;
    logic        scl, rel, sda, sda_out, sda_oe_n, meas_start;
    logic        dist_valid, dist_settled, comp_valid, comp_active;
    logic [11:0] dist_out;
    logic [7:0]  comp_idx, run_control, capture_setup, accum_count, lo, hi;
    logic [23:0] comp_data;
    logic [23:0] px[220];
    int          n_fail = 0;
    int          comparisons = 0;
    int          starts = 0;
    int          hist[$];
    int          k, idx, d;
    assign sda = (sda_oe_n | sda_out) & rel;
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (meas_start === 1'b1)
            starts++;
    dmcc_top dmcc_top_i (.ref_clk, .resetn, .scl, .sda_in(sda), .sda_out, .sda_oe_n,
        .meas_valid, .meas_dist, .exposure_value, .gain_factor, .prof_we, .prof_idx,
        .prof_data, .dist_valid, .dist_out, .dist_settled, .comp_valid, .comp_idx,
        .comp_data, .comp_active, .meas_start, .run_control, .capture_setup, .accum_count);
    dmcc_host dmcc_host_i (.ref_clk, .sda, .scl, .rel);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic rchk(input logic [7:0] off, input logic [7:0] exp);
        dmcc_host_i.rd(off, 1);
        chk("register", dmcc_host_i.rq[0], exp);
    endtask
    // Reference median: newest raw value until the window is full
    task automatic meas(input int n);
        int q[$];
        int v;
        v = $urandom % 4096;
        hist.push_back(v);
        if (hist.size() > n)
            void'(hist.pop_front());
        q = hist;
        q.sort();
        @(posedge ref_clk) meas_valid <= 1'b1;
        meas_dist <= v[11:0];
        @(posedge ref_clk) meas_valid <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("dist_valid", dist_valid, 1);
        chk("dist_out", dist_out, hist.size() < n ? v : q[n / 2]);
        chk("dist_settled", dist_settled, hist.size() == n);
    endtask
    task automatic pix(input int i, input int dv, input int e);
        @(posedge ref_clk) prof_we <= 1'b1;
        prof_idx <= 8'(i);
        prof_data <= 24'(dv);
        @(posedge ref_clk) prof_we <= 1'b0;
        #1;
        chk("comp_valid", comp_valid, 1);
        chk("comp_idx", comp_idx, i);
        chk("comp_data", comp_data, e);
    endtask
    initial
    begin
        void'($urandom(55));
        exposure_value <= 16'($urandom);
        gain_factor <= 8'($urandom);
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        chk("run_control", run_control, 8'h01);
        chk("accum_count", accum_count, 8'h0a);
        rchk(OFF_MEDIAN_WINDOW, 8'h01);
        rchk(OFF_COMP_ENABLE, 8'h00);
        foreach (WINS[j])
        begin
            dmcc_host_i.wr(OFF_MEDIAN_WINDOW, WINS[j]);
            rchk(OFF_MEDIAN_WINDOW, WINS[j]);
            hist.delete();
            repeat (12) meas(WINS[j] inside {5, 7, 9} ? WINS[j] : 1);
        end
        dmcc_host_i.wr(OFF_BANK_SELECT, PRIMARY_BANK_CODE);
        dmcc_host_i.wr(OFF_MEAS_TRIGGER, TRIGGER_CODE);
        repeat (WAIT_CYC * 2) @(posedge ref_clk);
        chk("meas_start", starts, 1);
        dmcc_host_i.rd(OFF_EXPOSURE_HIGH, 2);
        chk("exposure", {dmcc_host_i.rq[0], dmcc_host_i.rq[1]}, exposure_value);
        dmcc_host_i.wr(OFF_GAIN_CODE, ~gain_factor);
        rchk(OFF_GAIN_CODE, gain_factor);
        dmcc_host_i.wr(OFF_RUN_CONTROL, 8'h00);
        repeat (WAIT_CYC) @(posedge ref_clk);
        dmcc_host_i.wr(OFF_CAPTURE_SETUP, 8'h10);
        repeat (WAIT_CYC) @(posedge ref_clk);
        chk("run_control", run_control, 8'h00);
        chk("capture_setup", capture_setup, 8'h10);
        for (int i = 0; i < PROFILE_LEN; i++)
        begin
            px[i] = 24'($urandom);
            pix(i, px[i], px[i]);
        end
        for (int p = 0; p < 3; p++)
        begin
            dmcc_host_i.wr(OFF_PLANE_SELECT, PLANE_LOW_CODE + 8'(p));
            dmcc_host_i.rd(8'h00, PROFILE_LEN);
            for (int i = 0; i < PROFILE_LEN; i++)
                chk("plane", dmcc_host_i.rq[i], px[i][8 * p +: 8]);
        end
        dmcc_host_i.wr(OFF_PLANE_SELECT, 8'h00);
        rchk(8'h00, 8'h00);
        dmcc_host_i.wr(OFF_RUN_CONTROL, 8'h01);
        chk("run_control", run_control, 8'h01);
        lo = 8'($urandom);
        hi = 8'($urandom);
        k = {hi[4:0], lo[7:2]};
        dmcc_host_i.wr(OFF_COEFF_LOW, lo);
        dmcc_host_i.wr(OFF_COEFF_HIGH, hi);
        pix(9, 24'h1234, 24'h1234);
        dmcc_host_i.wr(OFF_COMP_ENABLE, COMP_ON_CODE);
        chk("comp_active", comp_active, 1);
        for (int i = 0; i < 24; i++)
        begin
            idx = i == 23 ? 219 : (i * 37) % PROFILE_LEN;
            d = i % 3 == 0 ? $urandom % 4000 : $urandom % 16777216;
            pix(idx, d, d > k * idx ? d - k * idx : 0);
        end
        dmcc_host_i.wr(OFF_COMP_ENABLE, 8'h01);
        chk("comp_active", comp_active, 0);
        chk("nacks", dmcc_host_i.nacks, 0);
        report_and_stop;
    end
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        n_fail++;
        report_and_stop;
    end
endmodule
`default_nettype wire
